/* File: core/icache_attr_pkg.sv */
// constants for the instruction cache control and attribute block
package icache_attr_pkg;

	// -------------------------------------------------------------------
	// control register numbers
	// -------------------------------------------------------------------
	localparam logic [11:0] CACHE_CTRL_IDX = 12'h002;
	localparam logic [11:0] REGION0_IDX = 12'h004;
	localparam logic [11:0] REGION1_IDX = 12'h005;

	// -------------------------------------------------------------------
	// cache control fields
	// -------------------------------------------------------------------
	localparam int CACHE_ON_BIT = 31;
	localparam int LINE_INVAL_OFF_BIT = 28;
	localparam int FREEZE_LINES_BIT = 27;
	localparam int FLUSH_ALL_BIT = 24;
	localparam int UNCACHED_BURST_BIT = 10;
	localparam int DEF_NO_CACHE_BIT = 9;
	localparam int DEF_POSTED_BIT = 8;
	localparam int DEF_WRITE_LOCK_BIT = 5;
	localparam int FILL_SIZE_LSB = 0;
	// bits that hold state; flush_all is an action and never stored
	localparam logic [31:0] CACHE_CTRL_MASK = 32'h9800_0723;
	localparam logic [31:0] CACHE_CTRL_RESET = 32'h0000_0000;

	// -------------------------------------------------------------------
	// region register fields
	// -------------------------------------------------------------------
	localparam int REGION_BASE_LSB = 24;
	localparam int IGNORE_MASK_LSB = 16;
	localparam int REGION_ON_BIT = 15;
	localparam int PRIV_SEL_LSB = 13;
	localparam int REGION_NO_CACHE_BIT = 6;
	localparam int REGION_POSTED_BIT = 5;
	localparam int REGION_WRITE_LOCK_BIT = 2;
	localparam logic [31:0] REGION_MASK = 32'hffff_e064;
	localparam logic [31:0] REGION_RESET = 32'h0000_0000;

	// -------------------------------------------------------------------
	// privilege select and fetch size codes
	// -------------------------------------------------------------------
	localparam logic [1:0] PRIV_USER = 2'h0;
	localparam logic [1:0] PRIV_SUPER = 2'h1;
	localparam logic [1:0] FILL_LW_LAST = 2'h0;
	localparam logic [1:0] FILL_LW_UPPER = 2'h1;

	typedef enum logic [1:0] {
		SIZE_WORD,
		SIZE_LONG,
		SIZE_LINE
	} fetch_size_t;

	// -------------------------------------------------------------------
	// whole-cache invalidation sequence: one tag entry per cycle
	// -------------------------------------------------------------------
	localparam int TAG_ENTRIES = 32;
	localparam int TAG_INDEX_LSB = 4;

endpackage : icache_attr_pkg

/* File: core/icache_attr_control.sv */
// cache control, region attribute matching and invalidation sequencing
`timescale 1ns/100ps

module icache_attr_control #(
	parameter int ENTRIES = icache_attr_pkg::TAG_ENTRIES
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// processor control register writes
	input wire logic cpu_wr,
	input wire logic [11:0] cpu_idx,
	input wire logic [31:0] cpu_wdata,
	// debug module register access
	input wire logic dbg_wr,
	input wire logic dbg_rd,
	input wire logic [11:0] dbg_idx,
	input wire logic [31:0] dbg_wdata,
	output logic [31:0] dbg_rdata,
	output logic dbg_rvalid,
	// single line invalidation request
	input wire logic push_req,
	input wire logic [31:0] push_addr,
	// tag array invalidation port
	output logic tag_inval,
	output logic [$clog2(ENTRIES)-1:0] tag_inval_idx,
	output logic flush_busy,
	// instruction fetch decision
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_seq,
	input wire logic fetch_super,
	input wire logic fetch_sram,
	input wire logic target_valid,
	output logic fetch_stall,
	output logic fetch_done,
	output icache_attr_pkg::fetch_size_t fetch_size,
	output logic array_read_en,
	output logic fill_buf_load,
	output logic array_write_ok,
	// operand reference attributes
	input wire logic ref_req,
	input wire logic [31:0] ref_addr,
	input wire logic ref_super,
	input wire logic ref_write,
	input wire logic ref_sram,
	output logic attr_valid,
	output logic attr_no_cache,
	output logic attr_posted,
	output logic attr_hold_term,
	output logic attr_access_err
);
	import icache_attr_pkg::*;

	localparam int IW = $clog2(ENTRIES);

	// -------------------------------------------------------------------
	// parameter check
	// -------------------------------------------------------------------
	// the index comes from address bits [8:4], so only 32 entries fit
	if (ENTRIES != TAG_ENTRIES) begin : g_bad_entries
		$error("ENTRIES must equal the five-bit line index range");
	end

	// -------------------------------------------------------------------
	// register state
	// -------------------------------------------------------------------
	logic [31:0] cache_control_reg;
	logic [31:0] attr_region_reg0;
	logic [31:0] attr_region_reg1;
	logic [31:0] cache_control_next;
	logic [31:0] attr_region0_next;
	logic [31:0] attr_region1_next;
	logic [IW-1:0] flush_cnt_reg;
	logic flush_busy_reg;

	// debug wins when both masters write in the same cycle
	wire wr_any = dbg_wr | cpu_wr;
	wire [11:0] wr_idx = dbg_wr ? dbg_idx : cpu_idx;
	wire [31:0] wr_data = dbg_wr ? dbg_wdata : cpu_wdata;
	wire wr_ctrl = wr_any && (wr_idx == CACHE_CTRL_IDX);
	wire wr_reg0 = wr_any && (wr_idx == REGION0_IDX);
	wire wr_reg1 = wr_any && (wr_idx == REGION1_IDX);
	wire flush_start = wr_ctrl && wr_data[FLUSH_ALL_BIT];

	// -------------------------------------------------------------------
	// register write decode; reserved and action bits are never stored
	// -------------------------------------------------------------------
	assign cache_control_next = wr_ctrl ? (wr_data & CACHE_CTRL_MASK)
		: cache_control_reg;
	assign attr_region0_next = wr_reg0 ? (wr_data & REGION_MASK)
		: attr_region_reg0;
	assign attr_region1_next = wr_reg1 ? (wr_data & REGION_MASK)
		: attr_region_reg1;

	// control registers, all cleared by reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cache_control_reg <= CACHE_CTRL_RESET;
			attr_region_reg0 <= REGION_RESET;
			attr_region_reg1 <= REGION_RESET;
		end else begin
			cache_control_reg <= cache_control_next;
			attr_region_reg0 <= attr_region0_next;
			attr_region_reg1 <= attr_region1_next;
		end
	end

	// -------------------------------------------------------------------
	// field views
	// -------------------------------------------------------------------
	wire cache_on = cache_control_reg[CACHE_ON_BIT];
	wire line_inval_off = cache_control_reg[LINE_INVAL_OFF_BIT];
	wire freeze_lines = cache_control_reg[FREEZE_LINES_BIT];
	wire uncached_burst_on = cache_control_reg[UNCACHED_BURST_BIT];
	wire default_no_cache = cache_control_reg[DEF_NO_CACHE_BIT];
	wire default_posted_write = cache_control_reg[DEF_POSTED_BIT];
	wire default_write_lock = cache_control_reg[DEF_WRITE_LOCK_BIT];
	wire [1:0] fill_size_ctl = cache_control_reg[FILL_SIZE_LSB +: 2];

	// -------------------------------------------------------------------
	// debug read port: registered data, one-cycle valid
	// -------------------------------------------------------------------
	// unknown register numbers read as zero rather than stale data
	wire [31:0] rd_mux = (dbg_idx == CACHE_CTRL_IDX) ? cache_control_reg
		: (dbg_idx == REGION0_IDX) ? attr_region_reg0
		: (dbg_idx == REGION1_IDX) ? attr_region_reg1
		: 32'h0000_0000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dbg_rdata <= 32'h0000_0000;
			dbg_rvalid <= 1'b0;
		end else begin
			dbg_rdata <= dbg_rd ? rd_mux : dbg_rdata;
			dbg_rvalid <= dbg_rd;
		end
	end

	// -------------------------------------------------------------------
	// invalidation sequencer
	// -------------------------------------------------------------------
	// a push during a flush is dropped: the flush clears that entry anyway
	wire push_go = push_req && !line_inval_off && !flush_busy_reg;
	wire flush_last = flush_busy_reg && (flush_cnt_reg == IW'(ENTRIES - 1));

	// walk every tag entry, one per cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flush_busy_reg <= 1'b0;
			flush_cnt_reg <= '0;
		end else begin
			flush_busy_reg <= flush_start | (flush_busy_reg & !flush_last);
			flush_cnt_reg <= flush_busy_reg ? flush_cnt_reg + 1'b1
				: '0;
		end
	end

	// invalidation strobe toward the tag array
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tag_inval <= 1'b0;
			tag_inval_idx <= '0;
		end else begin
			tag_inval <= flush_busy_reg | push_go;
			tag_inval_idx <= flush_busy_reg ? flush_cnt_reg
				: push_addr[TAG_INDEX_LSB +: IW];
		end
	end

	assign flush_busy = flush_busy_reg;

	// -------------------------------------------------------------------
	// region matching
	// -------------------------------------------------------------------
	function automatic logic region_hit(input logic [31:0] r,
		input logic [31:0] a, input logic super_mode);
		logic [7:0] diff;
		logic priv_ok;
		diff = (a[31:24] ^ r[REGION_BASE_LSB +: 8])
			& ~r[IGNORE_MASK_LSB +: 8];
		priv_ok = r[PRIV_SEL_LSB + 1]
			| ((r[PRIV_SEL_LSB +: 2] == PRIV_SUPER) == super_mode);
		region_hit = r[REGION_ON_BIT] && priv_ok && (diff == 8'h00);
	endfunction : region_hit

	// pick attributes by priority: region 0, region 1, then defaults
	function automatic logic [2:0] eff_attr(input logic h0, input logic h1,
		input logic [31:0] r0, input logic [31:0] r1, input logic [2:0] dflt);
		logic [31:0] r;
		r = h0 ? r0 : r1;
		eff_attr = (h0 | h1) ? {r[REGION_NO_CACHE_BIT], r[REGION_POSTED_BIT],
			r[REGION_WRITE_LOCK_BIT]} : dflt;
	endfunction : eff_attr

	wire [2:0] dflt_attr = {default_no_cache, default_posted_write,
		default_write_lock};
	wire ref_hit0 = region_hit(attr_region_reg0, ref_addr, ref_super);
	wire ref_hit1 = region_hit(attr_region_reg1, ref_addr, ref_super);
	wire [2:0] ref_attr = eff_attr(ref_hit0, ref_hit1, attr_region_reg0,
		attr_region_reg1, dflt_attr);
	wire fet_hit0 = region_hit(attr_region_reg0, fetch_addr, fetch_super);
	wire fet_hit1 = region_hit(attr_region_reg1, fetch_addr, fetch_super);
	wire [2:0] fet_attr = eff_attr(fet_hit0, fet_hit1, attr_region_reg0,
		attr_region_reg1, dflt_attr);

	// -------------------------------------------------------------------
	// operand reference attributes, answered the cycle after the request
	// -------------------------------------------------------------------
	wire ref_eval = ref_req && !ref_sram;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			attr_valid <= 1'b0;
			attr_no_cache <= 1'b0;
			attr_posted <= 1'b0;
			attr_hold_term <= 1'b0;
			attr_access_err <= 1'b0;
		end else begin
			attr_valid <= ref_eval;
			attr_no_cache <= ref_eval & ref_attr[2];
			attr_posted <= ref_eval & ref_write & ref_attr[1] & !ref_attr[0];
			attr_hold_term <= ref_eval & ref_write & !ref_attr[1]
				& !ref_attr[0];
			attr_access_err <= ref_eval & ref_write & ref_attr[0];
		end
	end

	// -------------------------------------------------------------------
	// instruction fetch decision
	// -------------------------------------------------------------------
	// fetches wait while the flush walks the tag array
	assign fetch_stall = fetch_req & flush_busy_reg;
	wire fet_go = fetch_req && !flush_busy_reg && !fetch_sram;
	wire fet_cacheable = cache_on && !fet_attr[2];
	wire [1:0] lw_off = fetch_addr[3:2];
	wire table_long = ((fill_size_ctl == FILL_LW_LAST) && (lw_off == 2'h3))
		|| ((fill_size_ctl == FILL_LW_UPPER) && lw_off[1]);
	wire use_table = fet_cacheable || (cache_on && uncached_burst_on);
	wire odd_branch = !fetch_seq && fetch_addr[1];
	fetch_size_t size_sel;
	assign size_sel = !cache_on ? (odd_branch ? SIZE_WORD : SIZE_LONG)
		: !use_table ? SIZE_LONG
		: table_long ? SIZE_LONG : SIZE_LINE;
	// a frozen valid entry is never replaced; an invalid one may be
	wire wr_ok = fet_cacheable && !(freeze_lines && target_valid);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fetch_done <= 1'b0;
			fetch_size <= SIZE_LONG;
			array_read_en <= 1'b0;
			fill_buf_load <= 1'b0;
			array_write_ok <= 1'b0;
		end else begin
			fetch_done <= fet_go;
			fetch_size <= fet_go ? size_sel : fetch_size;
			array_read_en <= fet_go & cache_on;
			fill_buf_load <= fet_go & use_table;
			array_write_ok <= fet_go & wr_ok;
		end
	end

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	flush_length_a: assert property (
		flush_start && !flush_busy_reg |=> flush_busy_reg [*8] ##24
		flush_busy_reg ##1 !flush_busy_reg)
		else $error("flush did not last 32 cycles");
	flush_zero_a: assert property (
		dbg_rvalid && $past(dbg_idx) == CACHE_CTRL_IDX
		|-> !dbg_rdata[FLUSH_ALL_BIT])
		else $error("flush_all read back as one");
	push_inval_a: assert property (
		push_req && !flush_busy_reg && !line_inval_off
		|=> tag_inval && tag_inval_idx == $past(push_addr[8:4]))
		else $error("line push did not invalidate its entry");
	push_off_a: assert property (
		push_req && line_inval_off && !flush_busy_reg |=> !tag_inval)
		else $error("line push acted while disabled");
	cache_off_a: assert property (
		fetch_done && !$past(cache_on) |-> !array_read_en
		&& !array_write_ok && fetch_size != SIZE_LINE)
		else $error("disabled cache used the array");
	freeze_keep_a: assert property (
		fet_go && freeze_lines && target_valid |=> !array_write_ok)
		else $error("frozen valid line overwritten");
	burst_nc_a: assert property (
		fet_go && cache_on && uncached_burst_on && fet_attr[2]
		|=> fill_buf_load && !array_write_ok)
		else $error("noncacheable burst reached the array");
	fill_size_ctl_line_a: assert property (
		fet_go && cache_on && fill_size_ctl[1] && !fet_attr[2]
		|=> fetch_size == SIZE_LINE)
		else $error("fill size 1x did not fetch a line");
	lock_err_a: assert property (
		ref_req && !ref_sram && ref_write && ref_attr[0]
		|=> attr_access_err && !attr_posted)
		else $error("locked write not refused");
	sram_skip_a: assert property (
		ref_req && ref_sram |=> !attr_valid)
		else $error("SRAM reference evaluated");
	region_prio_a: assert property (
		ref_hit0 && ref_req && !ref_sram |=>
		attr_no_cache == $past(attr_region_reg0[REGION_NO_CACHE_BIT]))
		else $error("region 0 did not take priority");
	reserved_zero_a: assert property (
		dbg_rvalid |->
		(dbg_rdata & ~(CACHE_CTRL_MASK | REGION_MASK)) == 32'h0000_0000)
		else $error("reserved bits read as one");

	flush_c: cover property (flush_start ##1 flush_busy_reg [*8]);
	push_c: cover property (push_go ##1 tag_inval);
	burst_c: cover property (fill_buf_load && !array_write_ok);
	err_c: cover property (attr_access_err);

endmodule : icache_attr_control

/* File: verification/bus_partner.sv */
// processor core and debug module model driving the local-bus side
`timescale 1ns/100ps

module bus_partner (
	// clock
	input wire logic clk,
	// processor control register writes
	output logic cpu_wr,
	output logic [11:0] cpu_idx,
	output logic [31:0] cpu_wdata,
	// debug module access
	output logic dbg_wr,
	output logic dbg_rd,
	output logic [11:0] dbg_idx,
	output logic [31:0] dbg_wdata,
	input wire logic [31:0] dbg_rdata,
	input wire logic dbg_rvalid,
	// line push instruction
	output logic push_req,
	output logic [31:0] push_addr
);
	// ---------------------------------------------------------------
	// idle state and access tasks
	// ---------------------------------------------------------------
	// all strobes idle at time zero
	initial begin
		{cpu_wr, dbg_wr, dbg_rd, push_req} = 4'h0;
		{cpu_idx, dbg_idx} = 24'h0;
		{cpu_wdata, dbg_wdata, push_addr} = 96'h0;
	end

	// processor only writes; callers keep reserved bits zero
	task automatic cpu_write(input logic [11:0] i, input logic [31:0] d);
		@(posedge clk);
		cpu_wr <= 1'b1;
		cpu_idx <= i;
		cpu_wdata <= d;
		@(posedge clk);
		cpu_wr <= 1'b0;
		cpu_wdata <= ~d; // stale data must not look valid
	endtask : cpu_write

	// debug write, one strobe cycle
	task automatic dbg_write(input logic [11:0] i, input logic [31:0] d);
		@(posedge clk);
		dbg_wr <= 1'b1;
		dbg_idx <= i;
		dbg_wdata <= d;
		@(posedge clk);
		dbg_wr <= 1'b0;
		dbg_wdata <= ~d;
	endtask : dbg_write

	// debug read; an answer that never comes returns unknown
	task automatic dbg_read(input logic [11:0] i, output logic [31:0] d);
		int n;
		@(posedge clk);
		dbg_rd <= 1'b1;
		dbg_idx <= i;
		@(posedge clk);
		dbg_rd <= 1'b0;
		n = 0;
		#1;
		while (dbg_rvalid !== 1'b1 && n < 3) begin
			@(posedge clk);
			#1;
			n++;
		end
		d = (dbg_rvalid === 1'b1) ? dbg_rdata : 32'hxxxx_xxxx;
	endtask : dbg_read

	// line push instruction executed once
	task automatic push_line(input logic [31:0] a);
		@(posedge clk);
		push_req <= 1'b1;
		push_addr <= a;
		@(posedge clk);
		push_req <= 1'b0;
		push_addr <= ~a;
	endtask : push_line
endmodule : bus_partner

/* File: verification/tb_icache_attr_control.sv */
// self-checking bench for the cache control and attribute block
`timescale 1ns/100ps

module tb_icache_attr_control;
	import icache_attr_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cpu_wr, dbg_wr, dbg_rd, dbg_rvalid, push_req;
	logic [11:0] cpu_idx, dbg_idx;
	logic [31:0] cpu_wdata, dbg_wdata, dbg_rdata, push_addr, rd;
	logic tag_inval, flush_busy, fetch_stall, fetch_done;
	logic [4:0] tag_inval_idx;
	logic fetch_req = 1'b0, fetch_seq = 1'b0, fetch_super = 1'b0;
	logic fetch_sram = 1'b0, target_valid = 1'b0;
	logic ref_req = 1'b0, ref_super = 1'b0, ref_write = 1'b0;
	logic ref_sram = 1'b0;
	logic [31:0] fetch_addr = 32'h0, ref_addr = 32'h0;
	logic array_read_en, fill_buf_load, array_write_ok;
	fetch_size_t fetch_size;
	logic attr_valid, attr_no_cache, attr_posted, attr_hold_term;
	logic attr_access_err;
	int fails = 0;
	int comparisons = 0;

	bus_partner bp (.clk, .cpu_wr, .cpu_idx, .cpu_wdata, .dbg_wr, .dbg_rd,
		.dbg_idx, .dbg_wdata, .dbg_rdata, .dbg_rvalid, .push_req,
		.push_addr);

	icache_attr_control dut (.clk, .nrst, .cpu_wr, .cpu_idx, .cpu_wdata,
		.dbg_wr, .dbg_rd, .dbg_idx, .dbg_wdata, .dbg_rdata, .dbg_rvalid,
		.push_req, .push_addr, .tag_inval, .tag_inval_idx, .flush_busy,
		.fetch_req, .fetch_addr, .fetch_seq, .fetch_super, .fetch_sram,
		.target_valid, .fetch_stall, .fetch_done, .fetch_size,
		.array_read_en, .fill_buf_load, .array_write_ok, .ref_req,
		.ref_addr, .ref_super, .ref_write, .ref_sram, .attr_valid,
		.attr_no_cache, .attr_posted, .attr_hold_term, .attr_access_err);

	// ---------------------------------------------------------------
	// clock, checks and closing
	// ---------------------------------------------------------------
	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// one fetch decision; answer waited for under a bound
	task automatic fetch(input logic [31:0] a, input logic s, input logic tv,
			input logic [1:0] sz, input logic wok);
		int n;
		@(posedge clk);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		fetch_seq <= s;
		target_valid <= tv;
		@(posedge clk);
		fetch_req <= 1'b0;
		n = 0;
		#1;
		while (fetch_done !== 1'b1 && n < 3) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({31'h0, fetch_done}, 32'h1);
		chk({30'h0, fetch_size}, {30'h0, sz});
		chk({31'h0, array_write_ok}, {31'h0, wok});
	endtask : fetch

	// one operand reference; e is {no_cache, posted, hold, error}
	task automatic refer(input logic [31:0] a, input logic sup,
			input logic wr, input logic [3:0] e);
		int n;
		@(posedge clk);
		ref_req <= 1'b1;
		ref_addr <= a;
		ref_super <= sup;
		ref_write <= wr;
		@(posedge clk);
		ref_req <= 1'b0;
		n = 0;
		#1;
		while (attr_valid !== 1'b1 && n < 3) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({31'h0, attr_valid}, 32'h1);
		chk({28'h0, attr_no_cache, attr_posted, attr_hold_term,
			attr_access_err}, {28'h0, e});
	endtask : refer

	// counts invalidation pulses in the next cycles
	task automatic count_inval(input logic [4:0] idx, input int exp_n);
		int n;
		n = 0;
		repeat (3) begin
			#1;
			if (tag_inval === 1'b1) begin
				n++;
				chk({27'h0, tag_inval_idx}, {27'h0, idx});
			end
			@(posedge clk);
		end
		chk(n, exp_n);
	endtask : count_inval

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		bp.dbg_read(CACHE_CTRL_IDX, rd);
		chk(rd, 32'h0);
		bp.dbg_read(REGION0_IDX, rd);
		chk(rd, 32'h0);
		bp.dbg_read(REGION1_IDX, rd);
		chk(rd, 32'h0);
		bp.dbg_read(12'h003, rd);
		chk(rd, 32'h0);
	endtask : t_reset

	// whole invalidation with a fetch waiting on it
	task automatic t_flush();
		int inv, busy, bad;
		{inv, busy, bad} = '0;
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0100_0100);
		fetch_req <= 1'b1;
		repeat (40) begin
			#1;
			if (tag_inval === 1'b1) begin
				chk({27'h0, tag_inval_idx}, inv);
				inv++;
			end
			if (flush_busy === 1'b1)
				busy++;
			if (fetch_stall !== flush_busy)
				bad++;
			// a fetch must not be decided while the flush runs
			if (fetch_done === 1'b1 && flush_busy === 1'b1)
				bad++;
			@(posedge clk);
		end
		fetch_req <= 1'b0;
		chk(inv, 32);
		chk(busy, 32);
		chk(bad, 0);
		bp.dbg_read(CACHE_CTRL_IDX, rd);
		chk(rd, 32'h0000_0100);
	endtask : t_flush

	task automatic t_push();
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0);
		bp.push_line(32'h0000_0150);
		count_inval(5'h15, 1);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h1000_0000);
		bp.push_line(32'h0000_0150);
		count_inval(5'h15, 0);
	endtask : t_push

	// fetch sizing with the cache off and on
	task automatic t_fetch();
		logic [1:0] sz;
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0);
		fetch(32'h2, 1'b0, 1'b0, SIZE_WORD, 1'b0);
		chk({31'h0, array_read_en}, 32'h0);
		chk({31'h0, fill_buf_load}, 32'h0);
		fetch(32'h2, 1'b1, 1'b0, SIZE_LONG, 1'b0);
		for (int c = 0; c < 3; c++) begin
			bp.dbg_write(CACHE_CTRL_IDX, 32'h8000_0000 | c);
			for (int o = 0; o < 4; o++) begin
				sz = SIZE_LINE;
				if ((c == 0 && o == 3) || (c == 1 && o >= 2))
					sz = SIZE_LONG;
				fetch(o * 4, 1'b1, 1'b0, sz, 1'b1);
				chk({31'h0, array_read_en}, 32'h1);
			end
		end
		bp.dbg_write(CACHE_CTRL_IDX, 32'h8800_0002);
		fetch(32'h0, 1'b1, 1'b1, SIZE_LINE, 1'b0);
		chk({31'h0, fill_buf_load}, 32'h1);
		fetch(32'h0, 1'b1, 1'b0, SIZE_LINE, 1'b1);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h8000_0600);
		fetch(32'hc, 1'b1, 1'b0, SIZE_LONG, 1'b0);
		chk({31'h0, fill_buf_load}, 32'h1);
		fetch(32'h0, 1'b1, 1'b0, SIZE_LINE, 1'b0);
		chk({31'h0, fill_buf_load}, 32'h1);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h8000_0200);
		fetch(32'h0, 1'b1, 1'b0, SIZE_LONG, 1'b0);
		chk({31'h0, fill_buf_load}, 32'h0);
		// a fetch served by the SRAM gets no decision
		@(posedge clk);
		fetch_req <= 1'b1;
		fetch_sram <= 1'b1;
		@(posedge clk);
		fetch_req <= 1'b0;
		fetch_sram <= 1'b0;
		#1;
		chk({31'h0, fetch_done}, 32'h0);
	endtask : t_fetch

	// defaults, region matching, priority and locking
	task automatic t_attr();
		int n;
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0000_0100);
		refer(32'h2000_0000, 1'b0, 1'b1, 4'b0100);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0);
		refer(32'h2000_0000, 1'b0, 1'b1, 4'b0010);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0000_0220);
		refer(32'h2000_0000, 1'b0, 1'b1, 4'b1001);
		bp.dbg_write(CACHE_CTRL_IDX, 32'h0);
		bp.cpu_write(REGION0_IDX, 32'h1201_8040);
		bp.cpu_write(REGION1_IDX, 32'h1300_c020);
		bp.dbg_read(REGION0_IDX, rd);
		chk(rd, 32'h1201_8040);
		refer(32'h1300_0000, 1'b0, 1'b0, 4'b1000);
		refer(32'h1300_0000, 1'b1, 1'b1, 4'b0100);
		refer(32'h1200_0000, 1'b1, 1'b0, 4'b0000);
		refer(32'h1200_0000, 1'b0, 1'b0, 4'b1000);
		bp.cpu_write(REGION1_IDX, 32'h1300_c024);
		refer(32'h1300_0000, 1'b1, 1'b1, 4'b0001);
		bp.cpu_write(REGION0_IDX, 32'h1201_0040);
		refer(32'h1200_0000, 1'b0, 1'b0, 4'b0000);
		@(posedge clk);
		ref_req <= 1'b1;
		ref_sram <= 1'b1;
		@(posedge clk);
		ref_req <= 1'b0;
		ref_sram <= 1'b0;
		n = 0;
		repeat (3) begin
			#1;
			if (attr_valid === 1'b1)
				n++;
			@(posedge clk);
		end
		chk(n, 0);
	endtask : t_attr

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	// reset for four cycles, then the scenarios in order
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_flush();
		t_push();
		t_fetch();
		t_attr();
		conclude();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#(20000 * 5);
		fails++;
		conclude();
	end
endmodule : tb_icache_attr_control
